// *** shared/lrs_pkg.sv ***
// package: register map, field positions and reset values of the lcd reference bank
package lrs_pkg;
    // register indices (word addresses = index * 4)
    localparam logic [3:0] LRS_IDX_REF_CTRL = 4'h0;
    localparam logic [3:0] LRS_IDX_CONTRAST = 4'h1;
    localparam logic [3:0] LRS_IDX_SEG_BASE = 4'h4;
    localparam logic [3:0] LRS_IDX_PIX_BASE = 4'h8;
    localparam int LRS_ADDR_W = 6;
    // field positions
    localparam int LRS_BIT_IRE = 7;
    localparam int LRS_BIT_IRS = 6;
    localparam int LRS_BIT_IRI = 5;
    localparam int LRS_BIT_BIAS3 = 3;
    localparam int LRS_BIT_BIAS2 = 2;
    localparam int LRS_BIT_BIAS1 = 1;
    // writable masks; other bits are unimplemented
    localparam logic [7:0] LRS_REF_MASK = 8'hEE;
    localparam logic [7:0] LRS_CST_MASK = 8'h07;
    // reset values, then the contrast ladder short and full codes
    localparam logic [7:0] LRS_REF_RST = 8'h00;
    localparam logic [7:0] LRS_CST_RST = 8'h00;
    localparam logic [7:0] LRS_SEG_RST = 8'h00;
    localparam logic [2:0] LRS_CST_SHORT = 3'h0;
    localparam logic [2:0] LRS_CST_FULL = 3'h7;
    // bus answer state
    typedef enum logic [0:0]
    {
        LRS_IDLE = 1'b0,
        LRS_ACK = 1'b1
    } lrs_bus_type;
endpackage

// *** shared/lrs_reg_if.sv ***
// interface: register write strobe from the bus slave to the pixel bank, with its read data back
`timescale 1ns/1ps
interface lrs_reg_if;
    logic we;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bank (input we, input idx, input wdata, output rdata);
    modport bus (output we, output idx, output wdata, input rdata);
endinterface

// *** design/lrs_pix_bank.sv ***
// module: pixel data storage, no reset (contents unknown at power-on)
`timescale 1ns/1ps
module lrs_pix_bank
    import lrs_pkg::*;
#(
    parameter int NUM_BYTES = 4
)
(
    input wire logic clk_i,
    lrs_reg_if.bank rif,
    output logic [NUM_BYTES*8-1:0] pixels_o
);
    typedef struct packed
    {
        logic [NUM_BYTES-1:0][7:0] pix;
    } lrs_pix_type;
    lrs_pix_type st_r;
    lrs_pix_type st_nxt;
    logic [3:0] sel;

    // byte select; reset leaves the bits alone on purpose
    always_comb
    begin
        st_nxt = st_r;
        sel = rif.idx - LRS_IDX_PIX_BASE;
        rif.rdata = 8'h00;
        if (rif.idx >= LRS_IDX_PIX_BASE && sel < 4'(NUM_BYTES))
        begin
            rif.rdata = st_r.pix[sel];
            if (rif.we)
                st_nxt.pix[sel] = rif.wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        st_r <= st_nxt;
    end

    assign pixels_o = st_r.pix;
endmodule

// *** design/lrs_top.sv ***
// module: lcd reference, contrast, segment select and pixel register bank on wishbone
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module lrs_top
    import lrs_pkg::*;
#(
    parameter int SEG_REGS = 2,
    parameter int PIX_BYTES = 4
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [LRS_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic lcd_active_flag_i,
    input wire logic [SEG_REGS*8-1:0] pin_direction_control_i,
    input wire logic [SEG_REGS*8-1:0] pin_analog_select_i,
    output logic ref_power_o,
    output logic ref_coupled_o,
    output logic ref_source_sel_o,
    output logic ref_idle_off_o,
    output logic ladder_on_o,
    output logic bias_pin1_connect_o,
    output logic bias_pin2_connect_o,
    output logic bias_pin3_connect_o,
    output logic [2:0] contrast_ladder_select_o,
    output logic contrast_shorted_o,
    output logic [2:0] contrast_sevenths_o,
    output logic [SEG_REGS*8-1:0] segment_pin_select_o,
    output logic [SEG_REGS*8-1:0] pin_direction_o,
    output logic [SEG_REGS*8-1:0] pin_analog_o,
    output logic [PIX_BYTES*8-1:0] pixel_on_bit_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        lrs_bus_type bus;
        logic [31:0] rdata;
        logic [7:0] ref_ctrl;
        logic [7:0] contrast;
        logic [SEG_REGS-1:0][7:0] seg;
        logic ladder_on;
        logic lcd_active;
    } lrs_state_type;

    lrs_state_type st_r;
    lrs_state_type st_nxt;
    lrs_reg_if rif();
    logic [3:0] idx;
    logic [3:0] seg_off;
    logic wr_go;
    logic lane0;
    logic [7:0] rd_byte;

    // ************************************************************
    // bus decode
    // ************************************************************
    // only byte lane 0 carries data; writes without it are dropped
    assign idx = wb_adr_i[LRS_ADDR_W-1:2];
    assign lane0 = wb_sel_i[0];
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && lane0 && (st_r.bus == LRS_IDLE);
    assign seg_off = idx - LRS_IDX_SEG_BASE;

    // pixel bank shares the decoded strobe
    assign rif.we = wr_go;
    assign rif.idx = idx;
    assign rif.wdata = wb_dat_i[7:0];

    lrs_pix_bank #(
        .NUM_BYTES(PIX_BYTES)
    ) u_pix (
        .clk_i(clk_i),
        .rif(rif),
        .pixels_o(pixel_on_bit_o)
    );

    // read mux; unmapped addresses read zero and still ack
    always_comb
    begin
        rd_byte = 8'h00;
        if (idx == LRS_IDX_REF_CTRL)
            rd_byte = st_r.ref_ctrl & LRS_REF_MASK;
        else if (idx == LRS_IDX_CONTRAST)
            rd_byte = st_r.contrast & LRS_CST_MASK;
        else if (idx >= LRS_IDX_SEG_BASE && seg_off < 4'(SEG_REGS))
            rd_byte = st_r.seg[seg_off];
        else
            rd_byte = rif.rdata;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.lcd_active = lcd_active_flag_i;
        // one-cycle ack, then one idle cycle before the next request
        case (st_r.bus)
            LRS_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    st_nxt.bus = LRS_ACK;
                    st_nxt.rdata = {24'h00_0000, rd_byte};
                end
            end
            LRS_ACK:
            begin
                st_nxt.bus = LRS_IDLE;
            end
            default:
            begin
                st_nxt.bus = LRS_IDLE;
            end
        endcase
        if (wr_go)
        begin
            if (idx == LRS_IDX_REF_CTRL)
                st_nxt.ref_ctrl = wb_dat_i[7:0] & LRS_REF_MASK;
            else if (idx == LRS_IDX_CONTRAST)
                st_nxt.contrast = wb_dat_i[7:0] & LRS_CST_MASK;
            else if (idx >= LRS_IDX_SEG_BASE && seg_off < 4'(SEG_REGS))
                st_nxt.seg[seg_off] = wb_dat_i[7:0];
        end
        // ladder follows enable, but only while the lcd is active
        st_nxt.ladder_on = st_r.ref_ctrl[LRS_BIT_IRE] && st_r.lcd_active;
        if (rst_i)
        begin
            st_nxt.bus = LRS_IDLE;
            st_nxt.rdata = 32'h0000_0000;
            st_nxt.ref_ctrl = LRS_REF_RST;
            st_nxt.contrast = LRS_CST_RST;
            st_nxt.seg = '0;
            st_nxt.ladder_on = 1'b0;
            st_nxt.lcd_active = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_ack_o = (st_r.bus == LRS_ACK);
    assign wb_dat_o = st_r.rdata;

    // reference power and coupling also drop when lcd goes inactive
    assign ref_power_o = st_r.ladder_on;
    assign ref_coupled_o = st_r.ladder_on;
    assign ref_source_sel_o = st_r.ref_ctrl[LRS_BIT_IRS];
    assign ref_idle_off_o = st_r.ref_ctrl[LRS_BIT_IRI];
    assign ladder_on_o = st_r.ladder_on;

    // bias pins only switch the bias tap, pin controls pass untouched
    assign bias_pin1_connect_o = st_r.ref_ctrl[LRS_BIT_BIAS1];
    assign bias_pin2_connect_o = st_r.ref_ctrl[LRS_BIT_BIAS2];
    assign bias_pin3_connect_o = st_r.ref_ctrl[LRS_BIT_BIAS3];
    assign pin_direction_o = pin_direction_control_i;
    assign pin_analog_o = pin_analog_select_i;

    // contrast ladder: short at code 0, else code/7 of full resistance
    assign contrast_ladder_select_o = st_r.contrast[2:0];
    assign contrast_shorted_o = (st_r.contrast[2:0] == LRS_CST_SHORT);
    assign contrast_sevenths_o = st_r.contrast[2:0];

    assign segment_pin_select_o = st_r.seg;
endmodule

// *** sim/lrs_glass_model.sv ***
// model of the lcd glass: pixels darken where the pin is routed
`timescale 1ns/1ps
module lrs_glass_model
#(
    parameter int N = 16
)
(
    input wire logic [N-1:0] seg_en_i,
    input wire logic [N-1:0] pix_i,
    output logic [N-1:0] dark_o
);
    // a gpio pin never darkens the glass, whatever its data bit
    assign dark_o = seg_en_i & pix_i;
endmodule

// *** sim/lrs_top_sva.sv ***
// checker: port relations of the lcd reference bank
`timescale 1ns/1ps
module lrs_top_sva
    import lrs_pkg::*;
#(
    parameter int SEG_REGS = 2,
    parameter int PIX_BYTES = 4
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_we_i,
    input wire logic [LRS_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic lcd_active_flag_i,
    input wire logic [SEG_REGS*8-1:0] pin_direction_control_i,
    input wire logic [SEG_REGS*8-1:0] pin_direction_o,
    input wire logic ref_power_o,
    input wire logic ref_coupled_o,
    input wire logic ladder_on_o,
    input wire logic [2:0] contrast_ladder_select_o,
    input wire logic contrast_shorted_o,
    input wire logic [SEG_REGS*8-1:0] segment_pin_select_o,
    input wire logic [PIX_BYTES*8-1:0] pixel_on_bit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ack of a write whose request was taken one edge earlier
    sequence s_wr(logic [3:0] idx);
        wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == idx);
    endsequence
    a_ref_pair_rise: assert property ($rose(ref_power_o) |-> $rose(ref_coupled_o))
        else $error("reference power and coupling apart");
    a_pin_dir_pass: assert property (pin_direction_o == pin_direction_control_i)
        else $error("pin direction altered");
    a_contrast_short: assert property (
        contrast_shorted_o == (contrast_ladder_select_o == 3'h0))
        else $error("ladder short flag wrong");
    a_seg_write_lands: assert property (s_wr(LRS_IDX_SEG_BASE)
        |-> segment_pin_select_o[7:0] == $past(wb_dat_i[7:0]))
        else $error("segment select not stored");
    a_pix_write_lands: assert property (s_wr(LRS_IDX_PIX_BASE)
        |-> pixel_on_bit_o[7:0] == $past(wb_dat_i[7:0]))
        else $error("pixel byte not stored");
    a_ladder_flag_off: assert property (!$past(lcd_active_flag_i, 2)
        |-> !ladder_on_o && !ref_power_o)
        else $error("ladder on while lcd inactive");
    a_ref_read_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[5:2] == 4'h0)
        |-> (wb_dat_o & ~{24'h00_0000, LRS_REF_MASK}) == 32'h0000_0000)
        else $error("unimplemented reference bit read nonzero");
endmodule
bind lrs_top lrs_top_sva #(.SEG_REGS(SEG_REGS), .PIX_BYTES(PIX_BYTES)) lrs_top_sva_i (.clk_i,
    .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lcd_active_flag_i,
    .pin_direction_control_i, .pin_direction_o, .ref_power_o, .ref_coupled_o, .ladder_on_o,
    .contrast_ladder_select_o, .contrast_shorted_o, .segment_pin_select_o, .pixel_on_bit_o);

// *** sim/lrs_top_test.sv ***
// testbench: register rows, contrast codes, reference gating and reset cases
`timescale 1ns/1ps
module lrs_top_test
    import lrs_pkg::*;
;
    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} lrs_row_type;
    lrs_row_type rows [6] = '{'{6'h00, 8'hFF, 8'hEE}, '{6'h04, 8'hFF, 8'h07},
        '{6'h10, 8'hA5, 8'hA5}, '{6'h14, 8'h5A, 8'h5A}, '{6'h20, 8'h3C, 8'h3C},
        '{6'h3C, 8'h77, 8'h00}};
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lcd_active_flag_i = 0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, pixel_on_bit_o;
    logic [15:0] pin_direction_control_i = 16'h0000, pin_analog_select_i = 16'h0000;
    logic wb_ack_o, ref_power_o, ref_coupled_o, ladder_on_o, contrast_shorted_o;
    logic bias_pin1_connect_o, bias_pin2_connect_o, bias_pin3_connect_o;
    logic ref_source_sel_o, ref_idle_off_o;
    logic [2:0] contrast_ladder_select_o, contrast_sevenths_o;
    logic [15:0] segment_pin_select_o, pin_direction_o, pin_analog_o, dark;
    int err_count = 0, compares = 0, cycles = 0;
    lrs_top lrs_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .lcd_active_flag_i, .pin_direction_control_i,
        .pin_analog_select_i, .ref_power_o, .ref_coupled_o, .ref_source_sel_o,
        .ref_idle_off_o, .ladder_on_o, .bias_pin1_connect_o, .bias_pin2_connect_o,
        .bias_pin3_connect_o, .contrast_ladder_select_o, .contrast_shorted_o,
        .contrast_sevenths_o, .segment_pin_select_o, .pin_direction_o, .pin_analog_o,
        .pixel_on_bit_o);
    lrs_glass_model lrs_glass_model_i (.seg_en_i(segment_pin_select_o),
        .pix_i(pixel_on_bit_o[15:0]), .dark_o(dark));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task results();
        $display("checks %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one classic cycle; holds everything until ack, then one idle cycle
    task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(a, 0, 8'h00);
        chk(nm, q, e);
    endtask
    // clock and hang guard; a hung handshake ends up here
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            results();
        end
    end
    // main sequence: rows first, then the awkward cases
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rdc("seg_reset", 6'h10, 32'h0000_0000);
        foreach (rows[i])
        begin
            bus(rows[i].a, 1, rows[i].d);
            rdc("row", rows[i].a, {24'h00_0000, rows[i].e});
        end
        chk("glass", dark[7:0], 8'h24);
        chk("src_idle", {ref_source_sel_o, ref_idle_off_o}, 2'b11);
        for (int c = 0; c < 8; c++)
        begin
            bus(6'h04, 1, c[7:0]);
            chk("sevenths", contrast_sevenths_o, c[2:0]);
            chk("select", contrast_ladder_select_o, c[2:0]);
            chk("shorted", contrast_shorted_o, c == 0);
        end
        bus(6'h00, 1, 8'h8E);
        chk("ladder_idle", ladder_on_o, 1'b0);
        chk("src_clear", {ref_source_sel_o, ref_idle_off_o}, 2'b00);
        lcd_active_flag_i <= 1;
        pin_direction_control_i <= 16'hA5C3;
        pin_analog_select_i <= 16'h3C5A;
        repeat (3) @(posedge clk_i);
        chk("power", {ref_power_o, ref_coupled_o, ladder_on_o}, 3'b111);
        chk("bias", {bias_pin3_connect_o, bias_pin2_connect_o, bias_pin1_connect_o}, 3'h7);
        chk("pins", {pin_direction_o, pin_analog_o}, 32'hA5C3_3C5A);
        lcd_active_flag_i <= 0;
        repeat (3) @(posedge clk_i);
        chk("gated", {ref_power_o, ladder_on_o}, 2'b00);
        // reset mid-run: selects clear, pixel data survives
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("reset_outs", {bias_pin3_connect_o, bias_pin2_connect_o, bias_pin1_connect_o,
            contrast_ladder_select_o, ref_power_o}, 7'h00);
        rdc("seg_again", 6'h10, 32'h0000_0000);
        rdc("pix_kept", 6'h20, 32'h0000_003C);
        results();
    end
endmodule
